/* File: shared/plsr_pkg.sv */
// constants, codes and register map of the indicator source and strap read-back bank
package plsr_pkg;
  // register port widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [15:0] ADDR_PLAIN_PIN_MODE_STATUS = 16'h0001;
  localparam logic [15:0] ADDR_INDICATOR_SEL = 16'h0460;
  localparam logic [15:0] ADDR_IO_CTRL = 16'h0461;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0462;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h0463;
  localparam logic [15:0] ADDR_STRAP_LOW = 16'h0467;
  localparam logic [15:0] ADDR_STRAP_CFG = 16'h0468;

  // indicator select fields
  localparam int SEL_W = 4;
  localparam int SEL_FIRST_LSB = 0;
  localparam int SEL_SECOND_LSB = 4;
  localparam logic [3:0] RST_SEL_FIRST = 4'h0;
  localparam logic [3:0] RST_SEL_SECOND = 4'h5;

  // strap read-back layout
  localparam int STRAP_LOW_W = 11;
  localparam logic [10:0] RST_STRAP_LOW = 11'h000;
  localparam logic [15:0] RST_STRAP_CFG = 16'h0087;
  localparam logic [15:0] STRAP_CFG_MASK = 16'h519f;
  localparam int CFG_ISOLATE_BIT = 14;
  localparam int CFG_AMDIX_BIT = 7;
  localparam int CFG_AUTONEG_BIT = 0;

  // interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_LINK_LOST = 0;
  localparam int IRQ_PRBS = 1;
  localparam int IRQ_MII_ERR = 2;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // timing: clock rate and indicator timings
  localparam int CLK_KHZ = 125000;
  localparam int BLINK_HALF_MS = 50;
  localparam int STRETCH_MS = 40;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int STRETCH_CYC = STRETCH_MS * CLK_KHZ;

  // indicator source codes
  typedef enum logic [3:0] {
    SRC_LINK = 4'h0, SRC_ACT = 4'h1, SRC_TX = 4'h2, SRC_RX = 4'h3,
    SRC_COL = 4'h4, SRC_SPEED100 = 4'h5, SRC_SPEED10 = 4'h6, SRC_FDX = 4'h7,
    SRC_LINK_BLINK = 4'h8, SRC_STRETCH = 4'h9, SRC_LINK100FD = 4'ha, SRC_LPI = 4'hb,
    SRC_MII_ERR = 4'hc, SRC_LINK_LOST = 4'hd, SRC_PRBS = 4'he, SRC_RSVD = 4'hf
  } plsr_src_t;

  // strap capture sequence, gray coded
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b11
  } plsr_fsm_t;

  // true for the one select code that must never light an indicator
  function automatic logic plsr_is_rsvd(input logic [3:0] sel);
    plsr_is_rsvd = (sel == SRC_RSVD);
  endfunction : plsr_is_rsvd
endpackage : plsr_pkg

/* File: rtl/plsr_src_mux.sv */
// source selector for one indicator output
`timescale 1ns/1ps
module plsr_src_mux (
  input wire logic [plsr_pkg::SEL_W-1:0] sel,
  input wire logic [15:0] src_vec,
  output logic lit
);
  import plsr_pkg::*;

  // the reserved code is forced dark even if a source drives its slot
  always_comb begin
    lit = plsr_is_rsvd(sel) ? 1'b0 : src_vec[sel];
  end
endmodule : plsr_src_mux

/* File: rtl/plsr_regs.sv */
// indicator source select, strap read-back and interrupt registers
`timescale 1ns/1ps
// Notes on behaviour
// - bits 7-4 pick second indicator, reset 5, extended only
// - bits 3-0 pick first indicator, reset 0
// - codes 0-7 map plain_pin_mode link status sources
// - codes 8-C map blink, stretch, link100fd, lpi, error
// - code D latches link loss until status read
// - code E latches test pattern error until cleared
// - plain mode: strap bit 14 drives mac isolation
// - strap low register shows eleven latched pins
// - strap config resets 0x87, bits 15,13 zero
// - io control register reads all zero
// - strap config bit 0 is inverted autoneg disable
module plsr_regs #(
  parameter int BLINK_HALF_CYCLES = plsr_pkg::BLINK_HALF_CYC,
  parameter int STRETCH_CYCLES = plsr_pkg::STRETCH_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [plsr_pkg::ADDR_W-1:0] addr,
  input wire logic [plsr_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [plsr_pkg::DATA_W-1:0] rdata,
  input wire logic extended_pin_mode,
  input wire logic [plsr_pkg::STRAP_LOW_W-1:0] strap_value_pins,
  input wire logic [15:0] strap_cfg_pins,
  input wire logic autoneg_disable_pin,
  input wire logic link_up,
  input wire logic tx_act,
  input wire logic rx_act,
  input wire logic collision,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic lpi_active,
  input wire logic mii_error,
  input wire logic prbs_error,
  input wire logic prbs_cnt_clear,
  output logic first_indicator,
  output logic second_indicator,
  output logic mac_pin_isolate,
  output logic autoneg_enable_strap,
  output logic irq
);
  import plsr_pkg::*;

  localparam int BLINK_W = $clog2(BLINK_HALF_CYCLES + 1);
  localparam int STRETCH_W = $clog2(STRETCH_CYCLES + 1);
  localparam logic [BLINK_W-1:0] BLINK_RELOAD = BLINK_W'(BLINK_HALF_CYCLES - 1);
  localparam logic [STRETCH_W-1:0] STRETCH_RELOAD = STRETCH_W'(STRETCH_CYCLES);

  typedef struct packed {
    plsr_fsm_t fsm;
    logic [SEL_W-1:0] sel_first;
    logic [SEL_W-1:0] sel_second;
    logic [STRAP_LOW_W-1:0] strap_low;
    logic [15:0] strap_cfg;
    logic link_d;
    logic link_lost;
    logic prbs_hold;
    logic [BLINK_W-1:0] blink_cnt;
    logic blink_ph;
    logic [STRETCH_W-1:0] stretch_cnt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic ind_first;
    logic ind_second;
    logic isolate;
  } plsr_state_t;

  plsr_state_t st;
  plsr_state_t next_st;
  logic [15:0] src_vec;
  logic [SEL_W-1:0] eff_sel [2];
  logic lit [2];
  logic any_act;
  logic link_fell;
  logic status_read;
  logic [IRQ_W-1:0] irq_events;

  // raw event terms shared by the source slots, the stretch window, the latches and the interrupt bits
  assign any_act = tx_act | rx_act;
  assign link_fell = st.link_d & ~link_up;
  assign status_read = rd_stb && (addr == ADDR_PLAIN_PIN_MODE_STATUS);

  // second select only counts in extended pin mode; plain mode keeps the reset source
  assign eff_sel[0] = st.sel_first;
  assign eff_sel[1] = extended_pin_mode ? st.sel_second : RST_SEL_SECOND;

  // source slots in code order; slot 15 is never lit
  always_comb begin
    src_vec = 16'h0000;
    src_vec[SRC_LINK] = link_up;
    src_vec[SRC_ACT] = any_act;
    src_vec[SRC_TX] = tx_act;
    src_vec[SRC_RX] = rx_act;
    src_vec[SRC_COL] = collision;
    src_vec[SRC_SPEED100] = speed_100;
    src_vec[SRC_SPEED10] = ~speed_100;
    src_vec[SRC_FDX] = full_duplex;
    src_vec[SRC_LINK_BLINK] = link_up & ~(any_act & st.blink_ph);
    src_vec[SRC_STRETCH] = (st.stretch_cnt != '0);
    src_vec[SRC_LINK100FD] = link_up & speed_100 & full_duplex;
    src_vec[SRC_LPI] = lpi_active;
    src_vec[SRC_MII_ERR] = mii_error;
    src_vec[SRC_LINK_LOST] = st.link_lost;
    src_vec[SRC_PRBS] = st.prbs_hold;
    src_vec[SRC_RSVD] = 1'b0;
  end

  // one selector per indicator
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ind
      plsr_src_mux u_mux (
        .sel(eff_sel[gi]),
        .src_vec(src_vec),
        .lit(lit[gi])
      );
    end
  endgenerate

  // events that feed the sticky interrupt bits
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_LINK_LOST] = link_fell;
    irq_events[IRQ_PRBS] = prbs_error;
    irq_events[IRQ_MII_ERR] = mii_error;
  end

  // next state of the whole bank
  always_comb begin
    next_st = st;
    next_st.link_d = link_up;
    next_st.rdata = '0;
    // straps are sampled one cycle after reset release so pins have settled
    case (st.fsm)
      ST_WAIT: begin
        next_st.fsm = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        next_st.fsm = ST_RUN;
        next_st.strap_low = strap_value_pins;
        next_st.strap_cfg = strap_cfg_pins & STRAP_CFG_MASK;
        next_st.strap_cfg[CFG_AMDIX_BIT] = ~strap_cfg_pins[CFG_AMDIX_BIT];
        next_st.strap_cfg[CFG_AUTONEG_BIT] = ~autoneg_disable_pin;
      end
      ST_RUN: begin
        next_st.fsm = ST_RUN;
      end
      default: begin
        next_st.fsm = ST_WAIT;
      end
    endcase
    // blink phase flips every half period, free running
    if (st.blink_cnt == '0) begin
      next_st.blink_cnt = BLINK_RELOAD;
      next_st.blink_ph = ~st.blink_ph;
    end else begin
      next_st.blink_cnt = st.blink_cnt - 1'b1;
    end
    // activity restarts the stretch window; idle lets it run down
    if (any_act) begin
      next_st.stretch_cnt = STRETCH_RELOAD;
    end else if (st.stretch_cnt != '0) begin
      next_st.stretch_cnt = st.stretch_cnt - 1'b1;
    end
    // link loss latch: a loss in the clearing cycle still wins
    if (status_read) begin
      next_st.link_lost = 1'b0;
    end
    if (link_fell) begin
      next_st.link_lost = 1'b1;
    end
    // test pattern error latch, held until the error counter clears
    if (prbs_cnt_clear) begin
      next_st.prbs_hold = 1'b0;
    end
    if (prbs_error) begin
      next_st.prbs_hold = 1'b1;
    end
    // register writes; upper select bits belong to another block
    if (wr_stb) begin
      case (addr)
        ADDR_INDICATOR_SEL: begin
          next_st.sel_first = wdata[SEL_FIRST_LSB +: SEL_W];
          next_st.sel_second = wdata[SEL_SECOND_LSB +: SEL_W];
        end
        ADDR_IRQ_MASK: begin
          next_st.irq_mask = wdata[IRQ_W-1:0];
        end
        default: begin
          next_st.irq_mask = st.irq_mask; // read-only and unmapped writes are dropped
        end
      endcase
    end
    // register reads, data valid in the following cycle only
    if (rd_stb) begin
      case (addr)
        ADDR_INDICATOR_SEL: begin
          next_st.rdata = {8'h00, st.sel_second, st.sel_first};
        end
        ADDR_IO_CTRL: begin
          next_st.rdata = 16'h0000;
        end
        ADDR_IRQ_STATUS: begin
          next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st.irq_stat};
          next_st.irq_stat = '0;
        end
        ADDR_IRQ_MASK: begin
          next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st.irq_mask};
        end
        ADDR_STRAP_LOW: begin
          next_st.rdata = {5'h00, st.strap_low};
        end
        ADDR_STRAP_CFG: begin
          next_st.rdata = st.strap_cfg & STRAP_CFG_MASK;
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end
    // sticky bits: new events override a read-clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | irq_events;
    // outputs taken from flops so lamps never glitch on select writes
    next_st.ind_first = lit[0];
    next_st.ind_second = lit[1];
    next_st.isolate = ~extended_pin_mode & st.strap_cfg[CFG_ISOLATE_BIT];
  end

  // state register; reset loads documented values only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st.fsm <= ST_WAIT;
      st.sel_first <= RST_SEL_FIRST;
      st.sel_second <= RST_SEL_SECOND;
      st.strap_low <= RST_STRAP_LOW;
      st.strap_cfg <= RST_STRAP_CFG;
      st.link_d <= 1'b0;
      st.link_lost <= 1'b0;
      st.prbs_hold <= 1'b0;
      st.blink_cnt <= '0;
      st.blink_ph <= 1'b0;
      st.stretch_cnt <= '0;
      st.irq_stat <= '0;
      st.irq_mask <= RST_IRQ_MASK;
      st.rdata <= '0;
      st.ind_first <= 1'b0;
      st.ind_second <= 1'b0;
      st.isolate <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // port drive
  assign rdata = st.rdata;
  assign first_indicator = st.ind_first;
  assign second_indicator = st.ind_second;
  assign mac_pin_isolate = st.isolate;
  assign autoneg_enable_strap = st.strap_cfg[CFG_AUTONEG_BIT];
  assign irq = |(st.irq_stat & st.irq_mask);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_second_sel_write: assert property (
    wr_stb && addr == ADDR_INDICATOR_SEL |=> st.sel_second == $past(wdata[7:4]))
    else $error("second select not written");

  chk_plain_second_src: assert property (
    !extended_pin_mode && $stable(extended_pin_mode) |=> second_indicator == $past(speed_100))
    else $error("plain mode second indicator not speed");

  chk_first_sel_write: assert property (
    wr_stb && addr == ADDR_INDICATOR_SEL |=> st.sel_first == $past(wdata[3:0]))
    else $error("first select not written");

  chk_code_fdx: assert property (
    st.sel_first == SRC_FDX && !wr_stb |=> first_indicator == $past(full_duplex))
    else $error("full duplex source wrong");

  chk_code_mii_err: assert property (
    st.sel_first == SRC_MII_ERR && !wr_stb |=> first_indicator == $past(mii_error))
    else $error("mii error source wrong");

  chk_link_lost_hold: assert property (
    st.link_lost && !status_read |=> st.link_lost)
    else $error("link lost latch dropped early");

  chk_link_lost_set: assert property (
    link_fell |=> st.link_lost ##1 (st.link_lost || $past(status_read)))
    else $error("link loss not latched");

  chk_prbs_latch: assert property (
    prbs_error ##1 !prbs_cnt_clear[*2] |=> st.prbs_hold)
    else $error("test pattern error not held");

  chk_isolate_strap: assert property (
    st.fsm == ST_RUN && !extended_pin_mode |=> mac_pin_isolate == st.strap_cfg[CFG_ISOLATE_BIT])
    else $error("isolation does not follow strap");

  chk_strap_low_read: assert property (
    rd_stb && addr == ADDR_STRAP_LOW |=> rdata == {5'h00, $past(st.strap_low)})
    else $error("strap low read back wrong");

  chk_strap_cfg_rsvd: assert property (
    rd_stb && addr == ADDR_STRAP_CFG |=> !rdata[15] && !rdata[13])
    else $error("strap config reserved bits set");

  chk_io_ctrl_zero: assert property (
    rd_stb && addr == ADDR_IO_CTRL |=> rdata == 16'h0000)
    else $error("io control not zero");

  chk_an_strap_inv: assert property (
    st.fsm == ST_CAPTURE |=> autoneg_enable_strap == !$past(autoneg_disable_pin))
    else $error("autoneg strap not inverted");

  chk_rsvd_dark: assert property (
    st.sel_first == SRC_RSVD && !wr_stb |=> !first_indicator)
    else $error("reserved code lit indicator");
endmodule : plsr_regs

/* File: tb/plsr_board_model.sv */
// board side model: strap resistors on shared pins and the two indicator lamps
`timescale 1ns/1ps
module plsr_board_model #(
  parameter logic [10:0] STRAP_LOW = 11'h5a3,
  parameter logic [15:0] STRAP_CFG = 16'hf016,
  parameter logic ANEG_OFF = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic first_indicator,
  input wire logic second_indicator,
  output logic [10:0] strap_value_pins,
  output logic [15:0] strap_cfg_pins,
  output logic autoneg_disable_pin,
  output logic [1:0] lamps
);
  logic [2:0] since_rst;
  // edges since reset release; straps are only held across the capture window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_rst <= 3'h0;
    end else if (since_rst != 3'h7) begin
      since_rst <= since_rst + 3'h1;
    end
  end
  // later the shared pins carry other traffic, so show the inverse to expose a late capture
  always_comb begin
    strap_value_pins = (since_rst < 3'h4) ? STRAP_LOW : ~STRAP_LOW;
    strap_cfg_pins = (since_rst < 3'h4) ? STRAP_CFG : ~STRAP_CFG;
    autoneg_disable_pin = (since_rst < 3'h4) ? ANEG_OFF : ~ANEG_OFF;
  end
  // lamps are plain active high loads
  assign lamps = {second_indicator, first_indicator};
endmodule : plsr_board_model

/* File: tb/plsr_regs_test.sv */
// self-checking bench for the indicator source and strap read-back bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, g, e); end end
module plsr_regs_test;
  import plsr_pkg::*;
  int failures = 0;
  int total_checks = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] addr = 16'h0;
  logic [15:0] wdata = 16'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic ext = 1'b1;
  logic [7:0] st = 8'h00; // link, tx, rx, col, speed100, fdx, lpi, mii error
  logic prbs = 1'b0;
  logic prbs_clr = 1'b0;
  logic [15:0] rdata;
  logic [15:0] d;
  logic l1, l2, iso, aneg, irq;
  logic [10:0] sv;
  logic [15:0] sc;
  logic ad;
  localparam logic [15:0] EXP_CFG = (16'hf016 & 16'h511e) | 16'h0080; // aneg pin high, amdix pin low

  plsr_regs #(.BLINK_HALF_CYCLES(4), .STRETCH_CYCLES(6)) i_plsr_regs (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .extended_pin_mode(ext), .strap_value_pins(sv), .strap_cfg_pins(sc), .autoneg_disable_pin(ad),
    .link_up(st[0]), .tx_act(st[1]), .rx_act(st[2]), .collision(st[3]), .speed_100(st[4]),
    .full_duplex(st[5]), .lpi_active(st[6]), .mii_error(st[7]), .prbs_error(prbs),
    .prbs_cnt_clear(prbs_clr), .first_indicator(l1), .second_indicator(l2),
    .mac_pin_isolate(iso), .autoneg_enable_strap(aneg), .irq(irq));
  plsr_board_model i_plsr_board_model (.clk(clk), .nrst(nrst), .first_indicator(l1),
    .second_indicator(l2), .strap_value_pins(sv), .strap_cfg_pins(sc), .autoneg_disable_pin(ad),
    .lamps());

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // indicators lag their source by one register stage
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic lamp(input logic [3:0] c, input logic [7:0] s);
    case (c)
      4'h0, 4'h8: lamp = s[0];
      4'h1: lamp = s[1] | s[2];
      4'h2: lamp = s[1];
      4'h3: lamp = s[2];
      4'h4: lamp = s[3];
      4'h5: lamp = s[4];
      4'h6: lamp = ~s[4];
      4'h7: lamp = s[5];
      4'h9: lamp = 1'b1;
      4'ha: lamp = s[0] & s[4] & s[5];
      4'hb: lamp = s[6];
      4'hc: lamp = s[7];
      default: lamp = 1'b0;
    endcase
  endfunction : lamp

  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // reset values, including a read on the first edge before the straps land
  task automatic t_reset;
    repeat (12) @(posedge clk);
    `CHK({l1, l2, iso, aneg, irq}, 5'b00010)
    nrst <= 1'b1;
    addr <= ADDR_STRAP_CFG;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 `CHK(rdata, 16'h0087)
  endtask : t_reset

  // map: reset contents, read-only places, reserved bits, unmapped address
  task automatic t_map;
    logic [15:0] a[5] = '{ADDR_INDICATOR_SEL, ADDR_IO_CTRL, ADDR_STRAP_LOW, ADDR_STRAP_CFG, 16'h0100};
    logic [15:0] e[5] = '{16'h0050, 16'h0000, 16'h05a3, EXP_CFG, 16'h0000};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        rd(a[i], d);
        `CHK(d, e[i])
        if (i > 0) wr(a[i], 16'hffff);
      end
    end
    `CHK(aneg, 1'b0)
    wr(ADDR_INDICATOR_SEL, 16'hffff);
    rd(ADDR_INDICATOR_SEL, d);
    `CHK(d, 16'h00ff)
  endtask : t_map

  // every plain source code on both fields against several status patterns
  task automatic t_codes;
    logic [7:0] pat[6] = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h3c, 8'h31};
    for (int c = 0; c < 13; c++) begin
      wr(ADDR_INDICATOR_SEL, {8'h00, c[3:0], c[3:0]});
      for (int i = 0; i < 6; i++) begin
        if ((c == 8) == (pat[i][1] | pat[i][2]) && c inside {8, 9}) continue;
        @(posedge clk);
        st <= pat[i];
        settle();
        `CHK({l1, l2}, {2{lamp(c[3:0], pat[i])}})
        `CHK(irq, 1'b0) // masked events stay quiet
      end
    end
  endtask : t_codes

  // blink and stretch timing with the short sim values: half period 4, stretch 6
  task automatic t_timing;
    int ones;
    ones = 0;
    wr(ADDR_INDICATOR_SEL, 16'h0098);
    st <= 8'h03;
    settle();
    // blink toggles every 4 cycles, so any 16 cycles hold exactly 8 lit ones
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      #1 ones += l1;
      `CHK(l2, 1'b1)
    end
    `CHK(ones, 8)
    @(posedge clk);
    st <= 8'h01;
    settle();
    `CHK({l1, l2}, 2'b11)
    // the stretch count of 6 plus the output stage has run out eight edges after idle
    repeat (5) @(posedge clk);
    #1 `CHK(l2, 1'b0)
  endtask : t_timing

  // plain pin mode: fixed second source and strap driven isolation
  task automatic t_plain;
    @(posedge clk);
    ext <= 1'b0;
    wr(ADDR_INDICATOR_SEL, 16'h0000);
    st <= 8'h10;
    settle();
    `CHK({l1, l2, iso}, 3'b011)
    @(posedge clk);
    st <= 8'h01;
    settle();
    `CHK({l1, l2}, 2'b10)
    @(posedge clk);
    ext <= 1'b1;
    settle();
    `CHK({l2, iso}, 2'b10)
  endtask : t_plain

  // link loss latch, masked and unmasked interrupts, clear on read
  task automatic t_loss;
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_INDICATOR_SEL, 16'h00dd);
    rd(ADDR_IRQ_STATUS, d);
    rd(ADDR_PLAIN_PIN_MODE_STATUS, d);
    settle();
    `CHK({l1, l2, irq}, 3'b000)
    @(posedge clk);
    st <= 8'h81;
    settle();
    `CHK(irq, 1'b0) // masked error only
    @(posedge clk);
    st <= 8'h00;
    settle();
    `CHK({l1, l2, irq}, 3'b111)
    @(posedge clk);
    st <= 8'h01;
    settle();
    `CHK({l1, l2}, 2'b11)
    rd(ADDR_IRQ_STATUS, d);
    `CHK(d, 16'h0005) // sticky events
    settle();
    `CHK({l1, irq}, 2'b10)
    rd(ADDR_PLAIN_PIN_MODE_STATUS, d);
    `CHK(d, 16'h0000) // unmapped here
    settle();
    `CHK({l1, l2}, 2'b00)
  endtask : t_loss

  // test pattern error latch, then the reserved code
  task automatic t_prbs;
    wr(ADDR_INDICATOR_SEL, 16'h00ee);
    prbs <= 1'b1;
    @(posedge clk);
    prbs <= 1'b0;
    repeat (10) @(posedge clk);
    #1 `CHK({l1, l2}, 2'b11)
    @(posedge clk);
    prbs_clr <= 1'b1;
    @(posedge clk);
    prbs_clr <= 1'b0;
    settle();
    `CHK({l1, l2}, 2'b00)
    wr(ADDR_INDICATOR_SEL, 16'h00ff);
    st <= 8'hff;
    settle();
    `CHK({l1, l2}, 2'b00)
  endtask : t_prbs

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  // main sequence
  initial begin
    t_reset();
    t_map();
    t_codes();
    t_timing();
    t_plain();
    t_loss();
    t_prbs();
    close_out();
  end
endmodule : plsr_regs_test
